/* File: hw/nljc_pkg.sv */
// Constants, selectors and state type for the node lookup and join config block.
// Assumes a single 50 MHz clock; every other file except the peer model refers to names here with nljc_pkg::.
package nljc_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ           = 50_000_000;
  localparam int unsigned WAIT_UNIT_MS     = 100;
  localparam int unsigned WAIT_UNIT_CYCLES = CLK_HZ / 1000 * WAIT_UNIT_MS;
  localparam int unsigned DIV_W            = 23;

  // Name buffer
  localparam int unsigned NAME_MAX = 20;
  localparam int unsigned IDX_W    = 5;

  // Frame types of the framed request and its response
  localparam logic [7:0] REQ_FRAME = 8'h08;
  localparam logic [7:0] RSP_FRAME = 8'h88;

  // Reset values
  localparam logic        ROLE_RST       = 1'h0;
  localparam logic [15:0] CHAN_MASK_RST  = 16'h1ffe;
  localparam logic [3:0]  LISTEN_EXP_RST = 4'h4;
  localparam logic [7:0]  JOIN_OPT_RST   = 8'h00;
  localparam logic [7:0]  HUB_OPT_RST    = 8'h00;
  localparam logic [7:0]  DISC_WAIT_RST  = 8'h19;
  localparam logic [15:0] OWN_SHORT_RST  = 16'h0000;

  // Legal ranges and special values
  localparam logic [7:0]  DISC_WAIT_MIN = 8'h01;
  localparam logic [7:0]  DISC_WAIT_MAX = 8'hfc;
  localparam logic [15:0] SHORT_OFF     = 16'hffff;
  localparam logic [15:0] HIPWR_AVAIL   = 16'h1ffe;
  localparam logic [15:0] ALL_AVAIL     = 16'hffff;
  localparam logic [7:0]  JOIN_OPT_MASK = 8'h0f;
  localparam logic [7:0]  HUB_OPT_MASK  = 8'h07;

  // Option bit positions
  localparam int unsigned JOIN_ANY_PAN  = 0;
  localparam int unsigned JOIN_ANY_CHAN = 1;
  localparam int unsigned JOIN_AUTO     = 2;
  localparam int unsigned JOIN_POLL     = 3;
  localparam int unsigned HUB_PAN_SCAN  = 0;
  localparam int unsigned HUB_ED_SCAN   = 1;
  localparam int unsigned HUB_ASSOC     = 2;

  // Scan timing in units of 10 us
  localparam logic [31:0] LISTEN_BASE_10US = 32'h0000_0600;
  localparam logic [31:0] PER_CHAN_10US    = 32'h0000_0ed8;
  localparam logic [31:0] FIXED_10US       = 32'h0000_07d0;

  // Configuration selectors
  localparam logic [2:0] CFG_ROLE   = 3'h0;
  localparam logic [2:0] CFG_CHAN   = 3'h1;
  localparam logic [2:0] CFG_LISTEN = 3'h2;
  localparam logic [2:0] CFG_JOIN   = 3'h3;
  localparam logic [2:0] CFG_HUB    = 3'h4;
  localparam logic [2:0] CFG_WAIT   = 3'h5;
  localparam logic [2:0] CFG_SHORT  = 3'h6;

  typedef enum logic [0:0] {ST_IDLE, ST_WAIT} nljc_state_t;

endpackage

/* File: hw/nljc_name_mem.sv */
// Small memory holding the node name being looked up, one byte per word.
// Assumes one writer and one reader on the same clock; read data is registered.
`timescale 1ns/1ps
module nljc_name_mem (
  input  wire logic                           clock,
  input  wire logic                           rst_n,
  input  wire logic                           wrEn,
  input  wire logic [nljc_pkg::IDX_W-1:0]     wrAddr,
  input  wire logic [7:0]                     wrData,
  input  wire logic [nljc_pkg::IDX_W-1:0]     rdAddr,
  output logic      [7:0]                     rdData
);

  typedef struct packed {
    logic [nljc_pkg::NAME_MAX-1:0][7:0] mem;
    logic [7:0]                         rd;
  } nljc_mem_state_t;

  nljc_mem_state_t s_ff;
  nljc_mem_state_t nxt_s;

  // Out-of-range reads return zero so a long peer name never matches
  always_comb begin
    nxt_s = s_ff;
    if (wrEn && (wrAddr < 5'(nljc_pkg::NAME_MAX))) begin
      nxt_s.mem[wrAddr] = wrData;
    end
    if (rdAddr < 5'(nljc_pkg::NAME_MAX)) begin
      nxt_s.rd = s_ff.mem[rdAddr];
    end else begin
      nxt_s.rd = 8'h00;
    end
  end

  // State register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rdData = s_ff.rd;

endmodule

/* File: hw/nljc_node_lookup.sv */
// Node name lookup, role selection, scan settings and join options of a radio node.
// Assumes host strobes come from logic on this clock; highPower and pinWake are pins.
`timescale 1ns/1ps
module nljc_node_lookup #(
  parameter int unsigned WAIT_UNIT_CYC = nljc_pkg::WAIT_UNIT_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        cfgWe,
  input  wire logic [2:0]  cfgSel,
  input  wire logic [15:0] cfgWdata,
  input  wire logic        cmdModeEnter,
  input  wire logic        nameWe,
  input  wire logic [7:0]  nameByte,
  input  wire logic        lookupGo,
  input  wire logic        lookupFramed,
  input  wire logic        peerValid,
  input  wire logic [7:0]  peerByte,
  input  wire logic        peerLast,
  input  wire logic [15:0] peerShort,
  input  wire logic [63:0] peerLong,
  input  wire logic        highPower,
  input  wire logic        pinWake,
  input  wire logic        candPanMatch,
  input  wire logic        candChanMatch,
  output logic             cmdMode,
  output logic             rolePick,
  output logic [15:0]      channelMask,
  output logic [3:0]       listenExponent,
  output logic [7:0]       joinerOptions,
  output logic [7:0]       hubJoinOptions,
  output logic [7:0]       discoveryWait,
  output logic [15:0]      ownShortAddr,
  output logic             shortAddrEn,
  output logic [31:0]      targetAddrHigh,
  output logic [31:0]      targetAddrLow,
  output logic             busy,
  output logic             discoverReq,
  output logic             replyValid,
  output logic             replyOk,
  output logic             replyFramed,
  output logic [7:0]       replyFrameType,
  output logic [15:0]      rspShortAddr,
  output logic [63:0]      rspLongAddr,
  output logic [4:0]       scanChanCount,
  output logic [31:0]      listenTime10us,
  output logic [31:0]      scanTime10us,
  output logic             panScanEn,
  output logic             energyScanEn,
  output logic             assocAccept,
  output logic             joinAnyPan,
  output logic             joinAnyChan,
  output logic             autoAssoc,
  output logic             joinAllowed,
  output logic             pollReq
);

  localparam logic [nljc_pkg::DIV_W-1:0] UNIT_LAST = 23'(WAIT_UNIT_CYC - 1);

  typedef struct packed {
    nljc_pkg::nljc_state_t     state;
    logic                      cmdMode;
    logic                      role;
    logic [15:0]               chanMask;
    logic [3:0]                listenExp;
    logic [7:0]                joinOpt;
    logic [7:0]                hubOpt;
    logic [7:0]                discWait;
    logic [15:0]               ownShort;
    logic [4:0]                nameLen;
    logic                      nameOver;
    logic                      framed;
    logic [4:0]                peerIdx;
    logic                      peerMatch;
    logic                      cmpValid;
    logic [7:0]                cmpByte;
    logic                      cmpLast;
    logic [4:0]                cmpIdx;
    logic [15:0]               capShort;
    logic [63:0]               capLong;
    logic [nljc_pkg::DIV_W-1:0] divCnt;
    logic [7:0]                waitCnt;
    logic [1:0]                hpSync;
    logic [2:0]                wakeSync;
    logic [31:0]               tgtHigh;
    logic [31:0]               tgtLow;
    logic [15:0]               rspShort;
    logic [63:0]               rspLong;
    logic                      discoverReq;
    logic                      replyValid;
    logic                      replyOk;
    logic                      pollReq;
    logic [4:0]                chanCount;
    logic [31:0]               listen10us;
    logic [31:0]               scan10us;
    logic [5:0]                enables;
  } nljc_state_all_t;

  nljc_state_all_t s_ff;
  nljc_state_all_t nxt_s;
  logic [7:0]      memRd;
  logic            memWe;
  logic            fin;
  logic            finOk;
  logic            hit;
  logic [15:0]     availMask;
  logic [31:0]     listenCalc;
  logic [4:0]      countCalc;

  // Name bytes are stored only while idle and only up to the buffer length
  assign memWe = nameWe && (s_ff.state == nljc_pkg::ST_IDLE)
                 && (s_ff.nameLen < 5'(nljc_pkg::NAME_MAX));

  nljc_name_mem u_name (
    .clock  (clock),
    .rst_n  (rst_n),
    .wrEn   (memWe),
    .wrAddr (s_ff.nameLen),
    .wrData (nameByte),
    .rdAddr (s_ff.peerIdx),
    .rdData (memRd)
  );

  // Scan arithmetic; high-power parts drop the unusable channels from the count
  always_comb begin
    availMask  = s_ff.hpSync[1] ? nljc_pkg::HIPWR_AVAIL : nljc_pkg::ALL_AVAIL;
    countCalc  = '0;
    for (int i = 0; i < 16; i++) begin
      countCalc = countCalc + 5'(s_ff.chanMask[i] & availMask[i]);
    end
    listenCalc = nljc_pkg::LISTEN_BASE_10US << s_ff.listenExp;
  end

  // Next-state logic
  always_comb begin
    nxt_s             = s_ff;
    nxt_s.discoverReq = 1'b0;
    nxt_s.replyValid  = 1'b0;
    nxt_s.pollReq     = 1'b0;
    nxt_s.cmpValid    = 1'b0;
    fin               = 1'b0;
    finOk             = 1'b0;
    hit               = 1'b0;
    nxt_s.hpSync      = {s_ff.hpSync[0], highPower};
    nxt_s.wakeSync    = {s_ff.wakeSync[1:0], pinWake};
    if (cmdModeEnter) begin
      nxt_s.cmdMode = 1'b1;
    end

    // Settings; out-of-range wait values are dropped rather than clamped
    if (cfgWe) begin
      if (cfgSel == nljc_pkg::CFG_ROLE) begin
        nxt_s.role = cfgWdata[0];
      end else if (cfgSel == nljc_pkg::CFG_CHAN) begin
        nxt_s.chanMask = cfgWdata;
      end else if (cfgSel == nljc_pkg::CFG_LISTEN) begin
        nxt_s.listenExp = cfgWdata[3:0];
      end else if (cfgSel == nljc_pkg::CFG_JOIN) begin
        nxt_s.joinOpt = cfgWdata[7:0] & nljc_pkg::JOIN_OPT_MASK;
      end else if (cfgSel == nljc_pkg::CFG_HUB) begin
        nxt_s.hubOpt = cfgWdata[7:0] & nljc_pkg::HUB_OPT_MASK;
      end else if (cfgSel == nljc_pkg::CFG_WAIT) begin
        if ((cfgWdata[7:0] >= nljc_pkg::DISC_WAIT_MIN) && (cfgWdata[15:8] == 8'h00)
            && (cfgWdata[7:0] <= nljc_pkg::DISC_WAIT_MAX)) begin
          nxt_s.discWait = cfgWdata[7:0];
        end
      end else if (cfgSel == nljc_pkg::CFG_SHORT) begin
        nxt_s.ownShort = cfgWdata;
      end
    end

    case (s_ff.state)
      nljc_pkg::ST_IDLE: begin
        if (nameWe) begin
          if (s_ff.nameLen < 5'(nljc_pkg::NAME_MAX)) begin
            nxt_s.nameLen = s_ff.nameLen + 5'h01;
          end else begin
            nxt_s.nameOver = 1'b1;
          end
        end
        if (lookupGo) begin
          nxt_s.framed = lookupFramed;
          if ((s_ff.nameLen == 5'h00) || s_ff.nameOver) begin
            fin = 1'b1;
          end else begin
            nxt_s.state       = nljc_pkg::ST_WAIT;
            nxt_s.discoverReq = 1'b1;
            nxt_s.divCnt      = '0;
            nxt_s.waitCnt     = 8'h00;
            nxt_s.peerIdx     = 5'h00;
            nxt_s.peerMatch   = 1'b1;
          end
        end
      end
      nljc_pkg::ST_WAIT: begin
        // Peer name bytes are compared one cycle later, when the stored byte is read
        if (peerValid) begin
          nxt_s.cmpValid = 1'b1;
          nxt_s.cmpByte  = peerByte;
          nxt_s.cmpLast  = peerLast;
          nxt_s.cmpIdx   = s_ff.peerIdx;
          if (peerLast) begin
            nxt_s.peerIdx  = 5'h00;
            nxt_s.capShort = peerShort;
            nxt_s.capLong  = peerLong;
          end else if (s_ff.peerIdx != 5'h1f) begin
            nxt_s.peerIdx = s_ff.peerIdx + 5'h01;
          end
        end
        if (s_ff.cmpValid) begin
          hit = s_ff.peerMatch && (s_ff.cmpIdx < s_ff.nameLen)
                && (memRd == s_ff.cmpByte);
          if (s_ff.cmpLast) begin
            nxt_s.peerMatch = 1'b1;
            if (hit && ((s_ff.cmpIdx + 5'h01) == s_ff.nameLen)) begin
              fin   = 1'b1;
              finOk = 1'b1;
            end
          end else begin
            nxt_s.peerMatch = hit;
          end
        end
        // Time-out in 100 ms steps; a match in the same cycle wins
        if (s_ff.divCnt == UNIT_LAST) begin
          nxt_s.divCnt  = '0;
          nxt_s.waitCnt = s_ff.waitCnt + 8'h01;
          if (!fin && ((s_ff.waitCnt + 8'h01) >= s_ff.discWait)) begin
            fin = 1'b1;
          end
        end else begin
          nxt_s.divCnt = s_ff.divCnt + 23'h000001;
        end
      end
      default: begin
        nxt_s.state = nljc_pkg::ST_IDLE;
      end
    endcase

    // Finish a lookup: reply, load addresses, and leave command mode on unframed success
    if (fin) begin
      nxt_s.state      = nljc_pkg::ST_IDLE;
      nxt_s.replyValid = 1'b1;
      nxt_s.replyOk    = finOk;
      nxt_s.nameLen    = 5'h00;
      nxt_s.nameOver   = 1'b0;
      nxt_s.cmpValid   = 1'b0;
      if (finOk && !nxt_s.framed) begin
        if (s_ff.capShort != nljc_pkg::SHORT_OFF) begin
          nxt_s.tgtHigh = 32'h0000_0000;
          nxt_s.tgtLow  = {16'h0000, s_ff.capShort};
        end else begin
          nxt_s.tgtHigh = s_ff.capLong[63:32];
          nxt_s.tgtLow  = s_ff.capLong[31:0];
        end
        nxt_s.cmdMode = 1'b0;
      end
      if (finOk && nxt_s.framed) begin
        nxt_s.rspShort = s_ff.capShort;
        nxt_s.rspLong  = s_ff.capLong;
      end
    end

    // Role-dependent enables: {join any pan, any chan, auto, pan scan, ed scan, accept}
    nxt_s.enables = {!s_ff.role && s_ff.joinOpt[nljc_pkg::JOIN_ANY_PAN],
                     !s_ff.role && s_ff.joinOpt[nljc_pkg::JOIN_ANY_CHAN],
                     !s_ff.role && s_ff.joinOpt[nljc_pkg::JOIN_AUTO],
                     s_ff.role && s_ff.hubOpt[nljc_pkg::HUB_PAN_SCAN],
                     s_ff.role && s_ff.hubOpt[nljc_pkg::HUB_ED_SCAN],
                     s_ff.role && s_ff.hubOpt[nljc_pkg::HUB_ASSOC]};
    if (s_ff.wakeSync[1] && !s_ff.wakeSync[2] && !s_ff.role
        && s_ff.joinOpt[nljc_pkg::JOIN_POLL]) begin
      nxt_s.pollReq = 1'b1;
    end
    // One listen exponent serves both roles' scans, so the time is shared
    nxt_s.chanCount  = countCalc;
    nxt_s.listen10us = listenCalc;
    nxt_s.scan10us   = 32'(countCalc * (listenCalc + nljc_pkg::PER_CHAN_10US))
                       + nljc_pkg::FIXED_10US;
  end

  // State register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_ff           <= '0;
      s_ff.role      <= nljc_pkg::ROLE_RST;
      s_ff.chanMask  <= nljc_pkg::CHAN_MASK_RST;
      s_ff.listenExp <= nljc_pkg::LISTEN_EXP_RST;
      s_ff.joinOpt   <= nljc_pkg::JOIN_OPT_RST;
      s_ff.hubOpt    <= nljc_pkg::HUB_OPT_RST;
      s_ff.discWait  <= nljc_pkg::DISC_WAIT_RST;
      s_ff.ownShort  <= nljc_pkg::OWN_SHORT_RST;
      s_ff.peerMatch <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs
  assign cmdMode        = s_ff.cmdMode;
  assign rolePick       = s_ff.role;
  assign channelMask    = s_ff.chanMask;
  assign listenExponent = s_ff.listenExp;
  assign joinerOptions  = s_ff.joinOpt;
  assign hubJoinOptions = s_ff.hubOpt;
  assign discoveryWait  = s_ff.discWait;
  assign ownShortAddr   = s_ff.ownShort;
  assign shortAddrEn    = (s_ff.ownShort != nljc_pkg::SHORT_OFF);
  assign targetAddrHigh = s_ff.tgtHigh;
  assign targetAddrLow  = s_ff.tgtLow;
  assign busy           = (s_ff.state == nljc_pkg::ST_WAIT);
  assign discoverReq    = s_ff.discoverReq;
  assign replyValid     = s_ff.replyValid;
  assign replyOk        = s_ff.replyOk;
  assign replyFramed    = s_ff.framed;
  assign replyFrameType = s_ff.framed ? nljc_pkg::RSP_FRAME : 8'h00;
  assign rspShortAddr   = s_ff.rspShort;
  assign rspLongAddr    = s_ff.rspLong;
  assign scanChanCount  = s_ff.chanCount;
  assign listenTime10us = s_ff.listen10us;
  assign scanTime10us   = s_ff.scan10us;
  assign {joinAnyPan, joinAnyChan, autoAssoc, panScanEn, energyScanEn, assocAccept}
                        = s_ff.enables;
  assign joinAllowed    = s_ff.enables[3] && (s_ff.enables[5] || candPanMatch)
                          && (s_ff.enables[4] || candChanMatch);
  assign pollReq        = s_ff.pollReq;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  cmd_exit_a: assert property (replyValid && replyOk && !replyFramed |-> !cmdMode)
    else $error("command mode kept after successful lookup");
  err_stay_a: assert property (replyValid && !replyOk |-> cmdMode == $past(cmdMode))
    else $error("command mode changed on error reply");
  empty_err_a: assert property (lookupGo && !busy && (s_ff.nameLen == 5'h00)
    |=> replyValid && !replyOk && !busy)
    else $error("empty name did not give an error reply");
  rsp_type_a: assert property (replyValid && replyFramed |-> replyFrameType == nljc_pkg::RSP_FRAME)
    else $error("framed reply has wrong frame type");
  tgt_short_a: assert property (replyValid && replyOk && !replyFramed
    && (s_ff.capShort != nljc_pkg::SHORT_OFF) |-> targetAddrLow == {16'h0000, s_ff.capShort}
    && targetAddrHigh == 32'h0000_0000)
    else $error("short target address not loaded");
  rsp_addr_a: assert property (replyValid && replyOk && replyFramed
    |-> rspShortAddr == s_ff.capShort && rspLongAddr == s_ff.capLong)
    else $error("framed reply addresses wrong");
  resv_zero_a: assert property (joinerOptions[7:4] == 4'h0 && hubJoinOptions[7:3] == 5'h00)
    else $error("reserved option bits not zero");
  // Enables lag the role by one register stage, so they follow the previous role
  role_gate_a: assert property ((panScanEn || energyScanEn || assocAccept)
    |-> $past(rolePick) && !(autoAssoc || joinAnyPan || joinAnyChan))
    else $error("role enables disagree with role");
  wait_range_a: assert property (discoveryWait >= nljc_pkg::DISC_WAIT_MIN
    && discoveryWait <= nljc_pkg::DISC_WAIT_MAX)
    else $error("discovery wait out of range");
  // Scan outputs read zero until the first edge after reset, so skip that edge
  scan_time_a: assert property ($past(rst_n) |-> scanTime10us == 32'(scanChanCount
    * (listenTime10us + nljc_pkg::PER_CHAN_10US)) + nljc_pkg::FIXED_10US)
    else $error("scan time does not match count and listen time");
  poll_cause_a: assert property (pollReq |-> $past(joinerOptions[3]) && !$past(rolePick))
    else $error("poll sent without option");

  ok_cmd_c: cover property (replyValid && replyOk && !replyFramed);
  ok_frame_c: cover property (replyValid && replyOk && replyFramed);
  timeout_c: cover property (busy ##1 replyValid && !replyOk);
  poll_c: cover property (pollReq);

endmodule

/* File: test/nljc_peer_model.sv */
// Peer radio node model: answers a name discovery with its label and addresses.
// Assumes the bench calls send while a lookup is waiting; drives at falling edges.
`timescale 1ns/1ps
module nljc_peer_model (
  input  wire logic clock,
  output logic        peerValid = 1'h0,
  output logic [7:0]  peerByte  = 8'h00,
  output logic        peerLast  = 1'h0,
  output logic [15:0] peerShort = 16'h0000,
  output logic [63:0] peerLong  = 64'h0
);
  // Bytes go back to back; released lines show inverted data so stale values never match
  task automatic send(input string nm, input logic [15:0] sh, input logic [63:0] lg);
    for (int i = 0; i < nm.len(); i++) begin
      @(negedge clock);
      peerValid = 1'h1;
      peerByte  = nm[i];
      peerLast  = (i == nm.len() - 1);
      peerShort = sh;
      peerLong  = lg;
    end
    @(negedge clock);
    peerValid = 1'h0;
    peerLast  = 1'h0;
    peerByte  = ~peerByte;
    peerShort = ~peerShort;
    peerLong  = ~peerLong;
  endtask
endmodule

/* File: test/tb_top.sv */
// Self-checking bench for the node lookup and join configuration block.
// Assumes a wait unit of 4 cycles so lookup time-outs stay short.
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [2:0] sel; logic [15:0] wd; logic [15:0] ex;} nljc_row_t;
  logic clock = 0, rst_n = 0, cfgWe = 0, cmdModeEnter = 0, nameWe = 0, lookupGo = 0;
  logic lookupFramed = 0, highPower = 0, pinWake = 0, candPanMatch = 0, candChanMatch = 0;
  logic [2:0]  cfgSel   = 3'h0;
  logic [15:0] cfgWdata = 16'h0000;
  logic [7:0]  nameByte = 8'h00;
  logic peerValid, peerLast, cmdMode, rolePick, shortAddrEn, busy, discoverReq, replyValid;
  logic replyOk, replyFramed, panScanEn, energyScanEn, assocAccept, joinAnyPan, joinAnyChan;
  logic autoAssoc, joinAllowed, pollReq;
  logic [7:0]  peerByte, joinerOptions, hubJoinOptions, discoveryWait, replyFrameType;
  logic [15:0] peerShort, channelMask, ownShortAddr, rspShortAddr;
  logic [63:0] peerLong, rspLongAddr;
  logic [31:0] targetAddrHigh, targetAddrLow, listenTime10us, scanTime10us;
  logic [3:0]  listenExponent;
  logic [4:0]  scanChanCount;
  int error_cnt = 0, n_checks = 0, n;
  // Settings table: selector, written value, expected readback
  nljc_row_t rows [8] = '{'{3'h0, 16'h0001, 16'h0001}, '{3'h1, 16'hffff, 16'hffff},
    '{3'h2, 16'h0006, 16'h0006}, '{3'h3, 16'h00ff, 16'h000f}, '{3'h4, 16'h00ff, 16'h0007},
    '{3'h5, 16'h00fd, 16'h0019}, '{3'h5, 16'h0003, 16'h0003}, '{3'h6, 16'hffff, 16'hffff}};
  logic [15:0] rstVal [7] = '{16'h0, 16'h1ffe, 16'h4, 16'h0, 16'h0, 16'h19, 16'h0};

  nljc_node_lookup #(.WAIT_UNIT_CYC(4)) uut (.*);
  nljc_peer_model peer (.*);

  always #10 clock = ~clock;

  task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
    n_checks++;
    if (got !== ex) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic test_done();
    if (error_cnt == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Readback of one setting, picked by its selector
  function automatic logic [15:0] rb(input logic [2:0] s);
    case (s)
      3'h0: rb = {15'h0, rolePick};
      3'h1: rb = channelMask;
      3'h2: rb = {12'h0, listenExponent};
      3'h3: rb = {8'h0, joinerOptions};
      3'h4: rb = {8'h0, hubJoinOptions};
      3'h5: rb = {8'h0, discoveryWait};
      default: rb = ownShortAddr;
    endcase
  endfunction

  // Derived enables and scan times need two cycles after the write
  task automatic cfg(input logic [2:0] s, input logic [15:0] d);
    @(negedge clock);
    cfgWe = 1'h1;
    cfgSel = s;
    cfgWdata = d;
    @(negedge clock);
    cfgWe = 1'h0;
    repeat (2) @(negedge clock);
  endtask

  // Command mode is entered with the first name byte, or with the start for an empty name
  task automatic lookup(input string nm, input logic fr, input logic cm);
    @(negedge clock);
    cmdModeEnter = cm;
    for (int i = 0; i < nm.len(); i++) begin
      nameWe = 1'h1;
      nameByte = nm[i];
      @(negedge clock);
      cmdModeEnter = 1'h0;
    end
    nameWe = 1'h0;
    lookupGo = 1'h1;
    lookupFramed = fr;
    @(negedge clock);
    lookupGo = 1'h0;
    cmdModeEnter = 1'h0;
  endtask

  // Bounded wait for the one-cycle reply; n holds the cycles taken
  task automatic waitReply(input int lim);
    for (n = 0; n < lim && replyValid !== 1'h1; n++) begin
      @(posedge clock);
      #1;
    end
    if (n == lim) begin
      chk("replyValid", 1, 0);
      test_done();
    end
  endtask

  initial begin
    repeat (3) @(negedge clock);
    for (int s = 0; s < 7; s++) chk("reset", rstVal[s], rb(s[2:0]));
    @(negedge clock);
    rst_n = 1'h1;
    foreach (rows[i]) begin
      cfg(rows[i].sel, rows[i].wd);
      chk("readback", rows[i].ex, rb(rows[i].sel));
    end
    chk("shortAddrEn", 0, shortAddrEn);
    chk("hubEnables", 3'h7, {panScanEn, energyScanEn, assocAccept});
    chk("autoAssoc", 0, autoAssoc);
    chk("chanCount", 16, scanChanCount);
    chk("listenTime", nljc_pkg::LISTEN_BASE_10US << 6, listenTime10us);
    chk("scanTime", 16 * (nljc_pkg::LISTEN_BASE_10US << 6) + 16 * nljc_pkg::PER_CHAN_10US
        + nljc_pkg::FIXED_10US, scanTime10us);
    highPower = 1'h1;
    repeat (5) @(negedge clock);
    chk("hpCount", 12, scanChanCount);
    highPower = 1'h0;
    // Wrong-case peer first, then the matching one
    lookup("Ab", 1'h0, 1'h1);
    chk("busy", 1, busy);
    chk("discoverReq", 1, discoverReq);
    peer.send("ab", 16'h5555, 64'h0);
    peer.send("Ab", 16'h1234, 64'h0102030405060708);
    waitReply(10);
    chk("okCmd", 1, replyOk);
    chk("target", 64'h1234, {targetAddrHigh, targetAddrLow});
    chk("cmdMode", 0, cmdMode);
    lookup("Zed", 1'h0, 1'h1);
    peer.send("Zed", 16'hffff, 64'h1122334455667788);
    waitReply(10);
    chk("targetLong", 64'h1122334455667788, {targetAddrHigh, targetAddrLow});
    lookup("Q", 1'h1, 1'h0);
    peer.send("Q", 16'h00ab, 64'h99aabbccddeeff00);
    waitReply(10);
    chk("rspType", 8'h88, replyFrameType);
    chk("rspFramed", 1, replyFramed);
    chk("rspAddr", {16'h00ab, 64'h99aabbccddeeff00}, {rspShortAddr, rspLongAddr});
    chk("targetKept", 64'h1122334455667788, {targetAddrHigh, targetAddrLow});
    // No peer answers: error after three wait units
    lookup("Ab", 1'h0, 1'h1);
    waitReply(30);
    chk("timeoutOk", 0, replyOk);
    chk("timeoutCyc", 12, n);
    chk("stayCmd", 1, cmdMode);
    lookup("", 1'h0, 1'h0);
    waitReply(3);
    chk("emptyOk", 0, replyOk);
    lookup("abcdefghijklmnopqrstu", 1'h0, 1'h0);
    waitReply(3);
    chk("longOk", 0, replyOk);
    chk("longIdle", 0, busy);
    cfg(3'h0, 16'h0000);
    cfg(3'h3, 16'h000c);
    chk("hubOff", 3'h0, {panScanEn, energyScanEn, assocAccept});
    candChanMatch = 1'h1;
    #1 chk("panGate", 0, joinAllowed);
    @(negedge clock);
    candPanMatch = 1'h1;
    candChanMatch = 1'h0;
    #1 chk("chanGate", 0, joinAllowed);
    @(negedge clock);
    candChanMatch = 1'h1;
    #1 chk("joinOk", 1, joinAllowed);
    @(negedge clock);
    pinWake = 1'h1;
    for (n = 0; n < 8 && pollReq !== 1'h1; n++) @(posedge clock) #1;
    chk("pollReq", 1, pollReq);
    cfg(3'h3, 16'h0000);
    chk("noAssoc", 0, joinAllowed);
    test_done();
  end
endmodule
